// ---- src/prbs_regs.vh ----
`ifndef PRBS_REGS_VH
`define PRBS_REGS_VH
// Register offsets
`define PRBS_OFS_OSC_CODE_LOW 8'h04
`define PRBS_OFS_RATE_HIGH 8'h05
`define PRBS_OFS_ACQ_BYPASS 8'h09
`define PRBS_OFS_OUT_CLOCK 8'h1E
`define PRBS_OFS_GEN_CTRL 8'h39
`define PRBS_OFS_RUN_LENGTH 8'h3A
`define PRBS_OFS_USER_WORD0 8'h3B
`define PRBS_OFS_USER_WORD1 8'h3C
`define PRBS_OFS_USER_WORD2 8'h3D
`define PRBS_OFS_USER_WORD3 8'h3E
`define PRBS_OFS_CHK_CTRL 8'h3F
`define PRBS_OFS_ERR_COUNT 8'h40
`define PRBS_OFS_ERR_FLAG 8'h41
`define PRBS_OFS_CAPTURE_LOW 8'h42
`define PRBS_OFS_CAPTURE_HIGH 8'h43
// Field positions
`define PRBS_BIT_RESTART 6
`define PRBS_BIT_BYPASS 5
`define PRBS_BIT_DDR_DISABLE 2
`define PRBS_BIT_RUN_VALUE 5
`define PRBS_BIT_RUN_ENABLE 4
`define PRBS_BIT_ENABLE 2
`define PRBS_BIT_CHK_CLEAR 3
// Pattern modes
`define PRBS_MODE_7 2'h0
`define PRBS_MODE_15 2'h1
`define PRBS_MODE_31 2'h2
`define PRBS_MODE_USER 2'h3
// Reset values, counts and I2C address
`define PRBS_CTRL_RESET 8'h00
`define PRBS_ERR_MAX 8'hFF
`define PRBS_LFSR_SEED 31'h7FFFFFFF
`define PRBS_CHK_SETTLE 5'h1F
`define PRBS_CAPTURE_BITS 5'h10
`define PRBS_I2C_ADDR 7'h40
`endif

// ---- src/prbs_lfsr.v ----
`timescale 1ns/1ns
`include "prbs_regs.vh"
module prbs_lfsr (
    input wire i_mclk,
    input wire i_resetn,
    input wire [1:0] i_mode,
    input wire i_step,
    input wire i_feed_ext,
    input wire i_bit,
    output reg o_pred
);
    reg [30:0] state_reg;

    always @* begin
        case (i_mode)
            `PRBS_MODE_7: o_pred = state_reg[6] ^ state_reg[5]; // RL12
            `PRBS_MODE_15: o_pred = state_reg[14] ^ state_reg[13]; // RL12
            default: o_pred = state_reg[30] ^ state_reg[27]; // RL12
        endcase
    end

    // Checker feeds received bits so it locks itself to any phase
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= `PRBS_LFSR_SEED;
        end else if (i_step) begin
            state_reg <= {state_reg[29:0], i_feed_ext ? i_bit : o_pred};
        end
    end
endmodule

// ---- src/prbs_buf.v ----
`timescale 1ns/1ns
module prbs_buf #(
    parameter W = 1
) (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] mem [0:1];
    reg wr_ptr_reg;
    reg rd_ptr_reg;
    reg [1:0] count_reg;
    wire push;
    wire pop;

    assign o_in_ready = (count_reg != 2'h2);
    assign o_out_valid = (count_reg != 2'h0);
    assign o_out_data = mem[rd_ptr_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule

// ---- src/prbs_test_top.v ----
// How it works
// RL1 - Full-rate flag and four-bit divider exponent readable for coarse rate.
// RL2 - Two-bit core field reports which of four oscillator cores runs. No core field is read back; 0x05 bits 1:0 hold oscillator code bits 9:8.
// RL3 - Ten-bit oscillator code split: low byte one register, top two next.
// RL4 - Writing one then zero to restart bit pulses new acquisition.
// RL5 - Checker enabled verifies data against PRBS7, PRBS15 or PRBS31 mode.
// RL6 - Checker mode 3 takes one sixteen-bit one-shot sample of data.
// RL7 - Writing one then zero to clear bit clears flag and counter.
// RL8 - Error flag and counter hold while checker is disabled.
// RL9 - Generator enabled outputs PRBS7, PRBS15 or PRBS31 by mode.
// RL10 - Generator mode 3 repeats the programmed 32-bit user word.
// RL11 - Run insertion adds runs of run bit, eight times length field.
// RL12 - Polynomials 1+x6+x7, 1+x14+x15, 1+x28+x31.
// RL13 - Output clock half data rate unless double-rate disable set.
// RL14 - Host must not pick full-rate clock in the top octave.
// RL15 - Bypass bit routes the raw input straight to output.
// RL16 - Host uses bypass only at or below 3.0 Gbps.
// RL17 - Error counter saturates at maximum instead of wrapping.
`timescale 1ns/1ns
`include "prbs_regs.vh"
module prbs_test_top #(
    parameter [6:0] I2C_ADDR = `PRBS_I2C_ADDR
) (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_scl,
    input wire i_sda,
    output wire o_sda_o,
    output reg o_sda_oe,
    input wire [9:0] i_oscillator_code,
    input wire i_full_rate_flag,
    input wire [3:0] i_rate_divider_exponent,
    input wire i_rx_data,
    input wire i_rx_valid,
    input wire i_raw_data,
    output wire o_tx_valid,
    input wire i_tx_ready,
    output wire o_tx_data,
    output reg o_out_clk,
    output reg o_full_rate_clk,
    output reg o_bypass,
    output reg o_acquisition_restart
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_WR = 6'h04;
    localparam [5:0] ST_ACK = 6'h08;
    localparam [5:0] ST_RD = 6'h10;
    localparam [5:0] ST_RACK = 6'h20;

    // Pin synchronisers; stage one feeds stage two only
    reg scl_s1_reg, scl_s2_reg, scl_d_reg;
    reg sda_s1_reg, sda_s2_reg, sda_d_reg;
    reg rxd_s1_reg, rxd_s2_reg, rxv_s1_reg, rxv_s2_reg;
    reg raw_s1_reg, raw_s2_reg;
    wire scl_rise = scl_s2_reg && !scl_d_reg;
    wire scl_fall = !scl_s2_reg && scl_d_reg;
    wire start_cond = scl_s2_reg && scl_d_reg && !sda_s2_reg && sda_d_reg;
    wire stop_cond = scl_s2_reg && scl_d_reg && sda_s2_reg && !sda_d_reg;

    reg [5:0] state_reg;
    reg [3:0] bitcnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] ptr_reg;
    reg have_ptr_reg;
    reg rw_reg;
    reg wr_en;
    reg [7:0] rd_data;

    // Control and status registers
    reg [7:0] acq_ctrl_reg;
    reg [7:0] clk_ctrl_reg;
    reg [7:0] gen_ctrl_reg;
    reg [7:0] run_len_reg;
    reg [31:0] user_word_reg;
    reg [7:0] chk_ctrl_reg;
    reg [7:0] err_count_reg;
    reg err_flag_reg;
    reg [15:0] capture_reg;
    reg chk_clear_pulse;

    assign o_sda_o = 1'b0;

    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            rxd_s1_reg <= 1'b0;
            rxd_s2_reg <= 1'b0;
            rxv_s1_reg <= 1'b0;
            rxv_s2_reg <= 1'b0;
            raw_s1_reg <= 1'b0;
            raw_s2_reg <= 1'b0;
        end else begin
            scl_s1_reg <= i_scl;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
            sda_s1_reg <= i_sda;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
            rxd_s1_reg <= i_rx_data;
            rxd_s2_reg <= rxd_s1_reg;
            rxv_s1_reg <= i_rx_valid;
            rxv_s2_reg <= rxv_s1_reg;
            raw_s1_reg <= i_raw_data;
            raw_s2_reg <= raw_s1_reg;
        end
    end

    // Read map; unlisted offsets read zero
    always @* begin
        case (ptr_reg)
            `PRBS_OFS_OSC_CODE_LOW: rd_data = i_oscillator_code[7:0]; // RL3
            `PRBS_OFS_RATE_HIGH: rd_data = {1'b0, i_full_rate_flag, // RL1
                i_rate_divider_exponent, i_oscillator_code[9:8]}; // RL3; no RL2 core field
            `PRBS_OFS_ACQ_BYPASS: rd_data = acq_ctrl_reg;
            `PRBS_OFS_OUT_CLOCK: rd_data = clk_ctrl_reg;
            `PRBS_OFS_GEN_CTRL: rd_data = gen_ctrl_reg;
            `PRBS_OFS_RUN_LENGTH: rd_data = run_len_reg;
            `PRBS_OFS_USER_WORD0: rd_data = user_word_reg[7:0];
            `PRBS_OFS_USER_WORD1: rd_data = user_word_reg[15:8];
            `PRBS_OFS_USER_WORD2: rd_data = user_word_reg[23:16];
            `PRBS_OFS_USER_WORD3: rd_data = user_word_reg[31:24];
            `PRBS_OFS_CHK_CTRL: rd_data = chk_ctrl_reg;
            `PRBS_OFS_ERR_COUNT: rd_data = err_count_reg;
            `PRBS_OFS_ERR_FLAG: rd_data = {7'h00, err_flag_reg};
            `PRBS_OFS_CAPTURE_LOW: rd_data = capture_reg[7:0];
            `PRBS_OFS_CAPTURE_HIGH: rd_data = capture_reg[15:8];
            default: rd_data = 8'h00;
        endcase
    end

    // I2C slave: pointer byte, then data bytes with auto-increment
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_IDLE;
            bitcnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            have_ptr_reg <= 1'b0;
            rw_reg <= 1'b0;
            wr_en <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            if (start_cond) begin
                state_reg <= ST_ADDR;
                bitcnt_reg <= 4'h0;
                have_ptr_reg <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state_reg <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        o_sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_WR: begin
                        if (scl_rise && bitcnt_reg != 4'h8) begin
                            shift_reg <= {shift_reg[6:0], sda_s2_reg};
                            bitcnt_reg <= bitcnt_reg + 4'h1;
                        end else if (scl_fall && bitcnt_reg == 4'h8) begin
                            bitcnt_reg <= 4'h0;
                            if (state_reg == ST_ADDR) begin
                                if (shift_reg[7:1] == I2C_ADDR) begin
                                    rw_reg <= shift_reg[0];
                                    o_sda_oe <= 1'b1;
                                    state_reg <= ST_ACK;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else begin
                                if (!have_ptr_reg) begin
                                    ptr_reg <= shift_reg;
                                    have_ptr_reg <= 1'b1;
                                end else begin
                                    wr_en <= 1'b1;
                                end
                                o_sda_oe <= 1'b1;
                                state_reg <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (wr_en) begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        if (scl_fall) begin
                            if (rw_reg) begin
                                shift_reg <= rd_data;
                                ptr_reg <= ptr_reg + 8'h01;
                                o_sda_oe <= !rd_data[7];
                                bitcnt_reg <= 4'h1;
                                state_reg <= ST_RD;
                            end else begin
                                o_sda_oe <= 1'b0;
                                state_reg <= ST_WR;
                            end
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            if (bitcnt_reg == 4'h8) begin
                                o_sda_oe <= 1'b0;
                                state_reg <= ST_RACK;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                o_sda_oe <= !shift_reg[6];
                                bitcnt_reg <= bitcnt_reg + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise && sda_s2_reg) begin
                            state_reg <= ST_IDLE;
                        end else if (scl_fall) begin
                            shift_reg <= rd_data;
                            ptr_reg <= ptr_reg + 8'h01;
                            o_sda_oe <= !rd_data[7];
                            bitcnt_reg <= 4'h1;
                            state_reg <= ST_RD;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Register writes; wr_en uses shift_reg before the pointer advances
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            acq_ctrl_reg <= `PRBS_CTRL_RESET;
            clk_ctrl_reg <= `PRBS_CTRL_RESET;
            gen_ctrl_reg <= `PRBS_CTRL_RESET;
            run_len_reg <= `PRBS_CTRL_RESET;
            user_word_reg <= 32'h00000000;
            chk_ctrl_reg <= `PRBS_CTRL_RESET;
            o_acquisition_restart <= 1'b0;
            chk_clear_pulse <= 1'b0;
        end else begin
            o_acquisition_restart <= 1'b0;
            chk_clear_pulse <= 1'b0;
            if (wr_en) begin
                case (ptr_reg)
                    `PRBS_OFS_ACQ_BYPASS: begin
                        acq_ctrl_reg <= shift_reg;
                        o_acquisition_restart <= acq_ctrl_reg[`PRBS_BIT_RESTART] &&
                            !shift_reg[`PRBS_BIT_RESTART]; // RL4
                    end
                    `PRBS_OFS_OUT_CLOCK: clk_ctrl_reg <= shift_reg;
                    `PRBS_OFS_GEN_CTRL: gen_ctrl_reg <= shift_reg;
                    `PRBS_OFS_RUN_LENGTH: run_len_reg <= shift_reg;
                    `PRBS_OFS_USER_WORD0: user_word_reg[7:0] <= shift_reg;
                    `PRBS_OFS_USER_WORD1: user_word_reg[15:8] <= shift_reg;
                    `PRBS_OFS_USER_WORD2: user_word_reg[23:16] <= shift_reg;
                    `PRBS_OFS_USER_WORD3: user_word_reg[31:24] <= shift_reg;
                    `PRBS_OFS_CHK_CTRL: begin
                        chk_ctrl_reg <= shift_reg;
                        chk_clear_pulse <= chk_ctrl_reg[`PRBS_BIT_CHK_CLEAR] &&
                            !shift_reg[`PRBS_BIT_CHK_CLEAR]; // RL7
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Generator
    wire gen_en = gen_ctrl_reg[`PRBS_BIT_ENABLE];
    wire [1:0] gen_mode = gen_ctrl_reg[1:0];
    wire run_en = gen_ctrl_reg[`PRBS_BIT_RUN_ENABLE] && (run_len_reg != 8'h00);
    wire buf_in_ready;
    wire gen_pred;
    reg [4:0] user_idx_reg;
    reg [10:0] run_cnt_reg;
    reg run_phase_reg;
    wire gen_step = gen_en && buf_in_ready;
    wire pat_step = gen_step && !run_phase_reg;
    wire [10:0] run_last = {run_len_reg, 3'h0} - 11'h001;
    wire gen_bit = run_phase_reg ? gen_ctrl_reg[`PRBS_BIT_RUN_VALUE] : // RL11
        (gen_mode == `PRBS_MODE_USER) ? user_word_reg[~user_idx_reg] : gen_pred; // RL10

    prbs_lfsr u_gen_lfsr (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_mode(gen_mode),
        .i_step(pat_step && gen_mode != `PRBS_MODE_USER), // RL9
        .i_feed_ext(1'b0),
        .i_bit(1'b0),
        .o_pred(gen_pred)
    );

    // Run and pattern segments alternate, each 8 x length bits long
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            user_idx_reg <= 5'h00;
            run_cnt_reg <= 11'h000;
            run_phase_reg <= 1'b0;
        end else begin
            if (pat_step && gen_mode == `PRBS_MODE_USER) begin
                user_idx_reg <= user_idx_reg + 5'h01; // RL10
            end
            if (!run_en || !gen_en) begin
                run_cnt_reg <= 11'h000;
                run_phase_reg <= 1'b0;
            end else if (gen_step) begin
                if (run_cnt_reg == run_last) begin // RL11
                    run_cnt_reg <= 11'h000;
                    run_phase_reg <= ~run_phase_reg;
                end else begin
                    run_cnt_reg <= run_cnt_reg + 11'h001;
                end
            end
        end
    end

    // Checker
    wire chk_en = chk_ctrl_reg[`PRBS_BIT_ENABLE];
    wire [1:0] chk_mode = chk_ctrl_reg[1:0];
    wire chk_pred;
    wire chk_step = chk_en && rxv_s2_reg && chk_mode != `PRBS_MODE_USER; // RL5
    reg [4:0] settle_reg;
    reg [4:0] cap_cnt_reg;
    wire chk_err = chk_step && (settle_reg == `PRBS_CHK_SETTLE) && (rxd_s2_reg != chk_pred);

    prbs_lfsr u_chk_lfsr (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_mode(chk_mode),
        .i_step(chk_step),
        .i_feed_ext(1'b1),
        .i_bit(rxd_s2_reg),
        .o_pred(chk_pred)
    );

    // Errors during the fill after enable are ignored
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            settle_reg <= 5'h00;
            cap_cnt_reg <= 5'h00;
            capture_reg <= 16'h0000;
            err_flag_reg <= 1'b0;
            err_count_reg <= 8'h00;
        end else begin
            if (!chk_step) begin
                if (!chk_en) begin
                    settle_reg <= 5'h00;
                end
            end else if (settle_reg != `PRBS_CHK_SETTLE) begin
                settle_reg <= settle_reg + 5'h01;
            end
            if (!chk_en || chk_mode != `PRBS_MODE_USER) begin
                cap_cnt_reg <= 5'h00;
            end else if (rxv_s2_reg && cap_cnt_reg != `PRBS_CAPTURE_BITS) begin
                capture_reg <= {capture_reg[14:0], rxd_s2_reg}; // RL6
                cap_cnt_reg <= cap_cnt_reg + 5'h01;
            end
            // Error wins over a clear in the same cycle
            if (chk_err) begin // RL8
                err_flag_reg <= 1'b1;
                if (chk_clear_pulse) begin
                    err_count_reg <= 8'h01;
                end else if (err_count_reg != `PRBS_ERR_MAX) begin // RL17
                    err_count_reg <= err_count_reg + 8'h01;
                end
            end else if (chk_clear_pulse) begin // RL7
                err_flag_reg <= 1'b0;
                err_count_reg <= 8'h00;
            end
        end
    end

    // Output path: bypass, generator, or recovered data
    wire bypass = acq_ctrl_reg[`PRBS_BIT_BYPASS];
    wire src_bit = bypass ? raw_s2_reg : gen_en ? gen_bit : rxd_s2_reg; // RL15 RL9
    wire src_valid = bypass || gen_en || rxv_s2_reg;
    wire tx_take = o_tx_valid && i_tx_ready;

    prbs_buf #(
        .W(1)
    ) u_out_buf (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_in_valid(src_valid),
        .o_in_ready(buf_in_ready),
        .i_in_data(src_bit),
        .o_out_valid(o_tx_valid),
        .i_out_ready(i_tx_ready),
        .o_out_data(o_tx_data)
    );

    // Mode follows o_full_rate_clk so the clock changes mode one edge after its flag
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_out_clk <= 1'b0;
            o_full_rate_clk <= 1'b0;
            o_bypass <= 1'b0;
        end else begin
            o_full_rate_clk <= clk_ctrl_reg[`PRBS_BIT_DDR_DISABLE]; // RL13
            o_bypass <= bypass; // RL15
            if (o_full_rate_clk) begin
                o_out_clk <= tx_take; // RL13
            end else if (tx_take) begin
                o_out_clk <= ~o_out_clk; // RL13
            end
        end
    end
endmodule

// ---- verif/prbs_test_monitor.sv ----
`timescale 1ns/1ns
module prbs_test_monitor (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_scl,
    input wire i_tx_ready,
    input wire o_sda_o,
    input wire o_sda_oe,
    input wire o_tx_valid,
    input wire o_tx_data,
    input wire o_out_clk,
    input wire o_full_rate_clk,
    input wire o_acquisition_restart
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_take;
        o_tx_valid && i_tx_ready;
    endsequence
    sequence s_stall;
        o_tx_valid && !i_tx_ready;
    endsequence
    a_restart_one_cycle: assert property (
        o_acquisition_restart |=> !o_acquisition_restart) else $error("restart too long");
    a_ddr_take_toggle: assert property (
        s_take ##0 !o_full_rate_clk |=> o_out_clk != $past(o_out_clk)) else $error("no toggle");
    a_ddr_idle_hold: assert property (
        !o_full_rate_clk && !(o_tx_valid && i_tx_ready) |=> $stable(o_out_clk))
        else $error("ddr clock moved without a bit");
    a_full_rate_mark: assert property (
        s_take ##0 o_full_rate_clk |=> o_out_clk) else $error("full rate clock missing");
    a_stall_valid_hold: assert property (
        s_stall |=> o_tx_valid) else $error("valid dropped in stall");
    a_stall_data_hold: assert property (
        s_stall |=> $stable(o_tx_data)) else $error("data changed in stall");
    // Open drain: the device may only pull low
    a_sda_open_drain: assert property (o_sda_o == 1'b0) else $error("sda driven high");
    a_sda_scl_low: assert property (
        $changed(o_sda_oe) |-> !i_scl) else $error("sda changed while scl high");
endmodule

bind prbs_test_top prbs_test_monitor u_mon (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_scl(i_scl), .i_tx_ready(i_tx_ready), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_out_clk(o_out_clk),
    .o_full_rate_clk(o_full_rate_clk), .o_acquisition_restart(o_acquisition_restart));

// ---- verif/prbs_host.sv ----
`timescale 1ns/1ns
module prbs_host (
    input wire i_mclk,
    input wire i_sda_oe,
    output reg o_scl,
    output wire o_sda
);
    localparam [6:0] ADDR = 7'h40;
    reg pull = 1'b0;
    reg [7:0] nak = 8'h00;
    reg a;
    reg [7:0] q;
    // Pull-up: line high unless a party pulls it
    assign o_sda = !(pull | i_sda_oe);
    initial o_scl = 1'b1;
    task hc(input integer n);
        begin
            repeat (n) @(posedge i_mclk);
            #1;
        end
    endtask
    // SDA only moves with SCL low, well clear of the sync delay
    task bitx(input b, output r);
        begin
            pull = !b;
            hc(10);
            o_scl = 1'b1;
            hc(10);
            r = o_sda;
            hc(10);
            o_scl = 1'b0;
            hc(10);
        end
    endtask
    task byte_x(input [7:0] d, output [7:0] r);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bitx(d[i], r[i]);
            bitx(1'b1, a);
            nak = nak + {7'h00, a};
        end
    endtask
    task start;
        begin
            pull = 1'b0;
            hc(10);
            o_scl = 1'b1;
            hc(20);
            pull = 1'b1;
            hc(20);
            o_scl = 1'b0;
            hc(10);
        end
    endtask
    task head(input [7:0] p);
        begin
            start;
            byte_x({ADDR, 1'b0}, q);
            byte_x(p, q);
        end
    endtask
    task wr(input [7:0] p, input [31:0] d, input integer n);
        integer i;
        begin
            head(p);
            for (i = 0; i < n; i = i + 1)
                byte_x(d[8*i+:8], q);
            wr_stop;
        end
    endtask
    // Single byte read ends with master NACK; ack bit not counted
    task rd(input [7:0] p, output [7:0] v);
        begin
            head(p);
            start;
            byte_x({ADDR, 1'b1}, q);
            for (int i = 7; i >= 0; i = i - 1)
                bitx(1'b1, v[i]);
            bitx(1'b1, a);
            wr_stop;
        end
    endtask
    task wr_stop;
        begin
            pull = 1'b1;
            hc(10);
            o_scl = 1'b1;
            hc(20);
            pull = 1'b0;
            hc(20);
        end
    endtask
endmodule

// ---- verif/prbs_test_and_rate_readback_bench.sv ----
`timescale 1ns/1ns
module prbs_test_and_rate_readback_bench;
    reg i_mclk = 1'b0;
    reg i_resetn = 1'b0;
    reg i_tx_ready = 1'b0;
    reg i_raw_data = 1'b1;
    wire scl, sda, sda_o, sda_oe, tx_valid, tx_data, out_clk, full_clk, bypass, restart;
    integer num_errors = 0;
    integer checks = 0;
    integer pulses = 0;
    integer cyc = 0;
    integer i;
    integer k;
    reg [7:0] v;
    reg [127:0] got;
    reg [14:0] rate_in = {1'b1, 4'h5, 10'h2BA};
    always #2 i_mclk = ~i_mclk;
    prbs_host host (.i_mclk(i_mclk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
    // Loopback: taken output bits come back as recovered data
    prbs_test_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_oscillator_code(rate_in[9:0]),
        .i_full_rate_flag(rate_in[14]), .i_rate_divider_exponent(rate_in[13:10]),
        .i_rx_data(tx_data), .i_rx_valid(tx_valid & i_tx_ready), .i_raw_data(i_raw_data),
        .o_tx_valid(tx_valid), .i_tx_ready(i_tx_ready), .o_tx_data(tx_data),
        .o_out_clk(out_clk), .o_full_rate_clk(full_clk), .o_bypass(bypass),
        .o_acquisition_restart(restart));
    task end_of_test;
        begin
            $display("checks %0d errors %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task cmp8(input string nm, input [7:0] e, input [7:0] g);
        cmp128(nm, {120'h0, e}, {120'h0, g});
    endtask
    task cmp128(input string nm, input [127:0] e, input [127:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("wrong value %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task rdc(input [7:0] p, input [7:0] e);
        begin
            host.rd(p, v);
            cmp8($sformatf("reg %h", p), e, v);
        end
    endtask
    // Clear is a one-then-zero write; waits let the loopback settle
    task clr(input [7:0] m);
        begin
            host.hc(500);
            host.wr(8'h3F, {24'h000000, m | 8'h08}, 1);
            host.wr(8'h3F, {24'h000000, m}, 1);
            host.hc(500);
        end
    endtask
    always @(posedge i_mclk) begin
        pulses = pulses + restart;
        cyc = cyc + 1;
        if (cyc == 95000) begin
            num_errors = num_errors + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (12) @(posedge i_mclk);
        #1 i_resetn = 1'b1;
        host.hc(5);
        rdc(8'h39, 8'h00);
        rdc(8'h04, 8'hBA);
        rdc(8'h05, 8'h56);
        rate_in = {1'b0, 4'hA, 10'h145};
        rdc(8'h04, 8'h45);
        rdc(8'h05, 8'h29);
        host.wr(8'h3A, 32'hC3A50F01, 4);
        host.wr(8'h39, 32'h00000037, 1);
        host.hc(20);
        i_tx_ready = 1'b1;
        got = 128'h0;
        i = 0;
        for (k = 0; i < 128 && k < 400; k = k + 1) begin
            @(negedge i_mclk);
            if (tx_valid === 1'b1) begin
                got = {got[126:0], tx_data};
                i = i + 1;
            end
        end
        #1;
        cmp128("user word", {2{64'h00FFC3FFA5FF0FFF}}, got);
        host.wr(8'h1E, 32'h00000004, 1);
        host.wr(8'h09, 32'h00000060, 1);
        host.wr(8'h09, 32'h00000020, 1);
        host.hc(20);
        cmp8("restart count", 8'h01, pulses[7:0]);
        cmp8("mode outputs", 8'h03, {6'h00, full_clk, bypass});
        cmp8("bypass data", 8'h01, {7'h00, tx_data});
        i_raw_data = 1'b0;
        host.hc(8);
        cmp8("bypass data", 8'h00, {7'h00, tx_data});
        host.wr(8'h09, 32'h00000000, 1);
        host.wr(8'h1E, 32'h00000000, 1);
        for (k = 0; k < 3; k = k + 1) begin
            host.wr(8'h39, 32'h00000004 + k, 1);
            host.wr(8'h3F, 32'h00000004 + k, 1);
            clr(8'h04 + k[7:0]);
            rdc(8'h40, 8'h00);
            rdc(8'h41, 8'h00);
        end
        host.wr(8'h39, 32'h00000005, 1);
        host.wr(8'h3F, 32'h00000004, 1);
        host.hc(3000);
        rdc(8'h40, 8'hFF);
        rdc(8'h41, 8'h01);
        host.wr(8'h3F, 32'h00000000, 1);
        host.hc(300);
        rdc(8'h40, 8'hFF);
        clr(8'h00);
        rdc(8'h40, 8'h00);
        rdc(8'h41, 8'h00);
        host.wr(8'h3B, 32'hFFFFFFFF, 4);
        host.wr(8'h39, 32'h00000007, 1);
        host.wr(8'h3F, 32'h00000007, 1);
        host.hc(200);
        rdc(8'h42, 8'hFF);
        rdc(8'h43, 8'hFF);
        host.wr(8'h20, 32'h000000FF, 1);
        rdc(8'h1E, 8'h00);
        cmp8("nack count", 8'h00, host.nak);
        end_of_test;
    end
endmodule
